// File: core/psz_map.vh
// Constants for the power-zone and phase-shedding control block.
// Assumes byte-wide registers reached at their printed offsets.
`ifndef PSZ_MAP_VH
`define PSZ_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSZ_ADDR_FSW_STAT    8'h2F
`define PSZ_ADDR_FSW_CFG     8'h30
`define PSZ_ADDR_FAST_DROP   8'h31
`define PSZ_ADDR_REQ_STAT    8'h32
`define PSZ_ADDR_PHASE_STAT  8'h33
`define PSZ_ADDR_ZONE_EN     8'h34
`define PSZ_ADDR_FIXED_STAT  8'h35
`define PSZ_ADDR_FIXED_CFG   8'h36
`define PSZ_ADDR_LL_STAT     8'h38
`define PSZ_ADDR_LL_CFG      8'h39
`define PSZ_ADDR_TH1_CFG     8'h3A
`define PSZ_ADDR_TH1_STAT    8'h3B
`define PSZ_ADDR_TH2_CFG     8'h3C
`define PSZ_ADDR_TH3_CFG     8'h3D
`define PSZ_ADDR_TH4_CFG     8'h3E
`define PSZ_ADDR_HYST_CFG    8'h42
`define PSZ_ADDR_DELAY_CFG   8'h43

// ----------------------------------------
// Reset values and threshold disable code
// ----------------------------------------
`define PSZ_RST_FSW          8'h00
`define PSZ_RST_FAST_DROP    8'h01
`define PSZ_RST_ZONE_EN      8'h1F
`define PSZ_RST_FIXED_CFG    8'h03
`define PSZ_RST_LL_CFG       8'h03
`define PSZ_RST_TH           8'h00
`define PSZ_RST_HYST         8'h44
`define PSZ_RST_DELAY        8'h14
`define PSZ_TH_DISABLED      8'hFF

// ----------------------------------------
// Fields and encodings
// ----------------------------------------
`define PSZ_FAST_DROP_EN_BIT 0
`define PSZ_LL_EN_BIT        2
`define PSZ_REQ_LOW          2'h0
`define PSZ_REQ_MID          2'h1
`define PSZ_REQ_HIGH         2'h2
`define PSZ_DROOP_OFF        2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSZ_CLK_MHZ          50
`define PSZ_SAMPLE_US        10
`define PSZ_FORCE_US         2000
`define PSZ_SAMPLE_CYCLES    (`PSZ_SAMPLE_US * `PSZ_CLK_MHZ)
`define PSZ_FORCE_CYCLES     (`PSZ_FORCE_US * `PSZ_CLK_MHZ)

`endif

// File: core/psz_phase_map.v
// Registered lookup from power zone and phase count to phase drive enables.
// Assumes phase_count holds 1..8 and zone 0..4, both from the same clock.
`timescale 1ns/10ps
`default_nettype none

module psz_phase_map #(
    parameter N_PHASE = 8
) (
    input  wire                 clk,
    input  wire                 sys_rst,
    input  wire [2:0]           zone,
    input  wire [3:0]           phase_count,
    input  wire                 force_all,
    output wire [N_PHASE-1:0]   drive_en
);

    reg [N_PHASE-1:0] en_q;

    // ----------------------------------------
    // One lookup per phase output
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < N_PHASE; i = i + 1) begin : g_ph
            reg on_d;
            always @* begin
                on_d = 1'b0;
                if (force_all || zone == 3'h0) begin
                    on_d = (i < phase_count); // [RL1]
                end else if (i == 0) begin
                    on_d = 1'b1; // [RL1]
                end else if (zone == 3'h1) begin
                    if (phase_count == 4'h8)
                        on_d = (i == 2) || (i == 4) || (i == 6); // [RL1]
                    else if (phase_count == 4'h7)
                        on_d = (i == 2) || (i == 3) || (i == 4) || (i == 6); // [RL2]
                end else if (zone == 3'h2) begin
                    if (phase_count == 4'h8)
                        on_d = (i == 4); // [RL1]
                    else if (phase_count == 4'h7)
                        on_d = (i == 3) || (i == 6); // [RL2]
                    else if (phase_count == 4'h6)
                        on_d = (i == 2) || (i == 4); // [RL2]
                    else if (phase_count == 4'h4)
                        on_d = (i == 2); // [RL2]
                end
            end
            always @(posedge clk) begin
                if (sys_rst)
                    en_q[i] <= 1'b0;
                else
                    en_q[i] <= on_d;
            end
        end
    endgenerate

    assign drive_en = en_q;

endmodule // psz_phase_map

`default_nettype wire

// File: core/psz_zone_ctrl.v
// Power-zone selection, phase shedding sequencer and its settings registers.
// Assumes synchronous inputs, an already digitized current monitor code
// (full scale = max load), and a byte register port at printed offsets.
`timescale 1ns/10ps
`default_nettype none
`include "psz_map.vh"

// Operation
// RL1 - Zone 0 all; 8-phase zones 1, 2 subsets
// RL2 - 7, 6, 4-phase subsets; others unavailable
// RL3 - Zone 4 light-load discontinuous, others continuous
// RL4 - Low request fixed zones; mid request thresholds
// RL5 - Mid request: compare current, adjust zone automatically
// RL6 - Rising current: move down without wait
// RL7 - Falling current: programmable delay, 10 us steps
// RL8 - Step through each enabled zone, delay each
// RL9 - Down above threshold, up below threshold minus hysteresis
// RL10 - Hysteresis resets 0x44, software writable
// RL11 - Skip and never settle in disabled zones
// RL12 - Fixed-mode change uses same stepped sequence
// RL13 - Fixed mode self-enables disabled target zone
// RL14 - Return to shedding drops self-enabled zones
// RL15 - Fast reference drop in zone 3/4: all on 2 ms
// RL16 - Frequency setting captured, readable, writable
// RL17 - Droop 0/25/50/100 percent, only with load line
// RL18 - Digitized current monitor is shedding compare input
// RL19 - High request keeps all configured phases on
// RL20 - Sample current every 10 us in shedding
// RL21 - Threshold 0xFF disables it and its zone
// RL22 - No shedding before output first regulates; code holds only the mid target, reset low mode still steps to the fixed zone
// RL23 - One zone at a time; cancel pending on demand
module psz_zone_ctrl #(
    parameter N_PHASE       = 8,
    parameter SAMPLE_CYCLES = `PSZ_SAMPLE_CYCLES,
    parameter FORCE_CYCLES  = `PSZ_FORCE_CYCLES
) (
    input  wire                 clk,
    input  wire                 sys_rst,
    input  wire [1:0]           power_state_request,
    input  wire [3:0]           phase_count,
    input  wire [7:0]           iout_code,
    input  wire                 output_in_regulation,
    input  wire                 fast_reference_drop,
    input  wire [7:0]           fsw_strap,
    input  wire                 reg_wr_en,
    input  wire                 reg_rd_en,
    input  wire [7:0]           reg_addr,
    input  wire [7:0]           reg_wr_data,
    output reg  [7:0]           reg_rd_data_q,
    output wire [N_PHASE-1:0]   phase_drive_en,
    output reg  [2:0]           zone_q,
    output reg                  dcm_mode_q,
    output reg  [1:0]           droop_coeff_q,
    output reg  [7:0]           switching_frequency_q
);

    localparam CNT_W = 17;
    localparam [CNT_W-1:0] SAMPLE_LAST = SAMPLE_CYCLES - 1;
    localparam [CNT_W-1:0] FORCE_LAST  = FORCE_CYCLES - 1;

    // Sequencer states
    localparam ST_HOLD = 2'h0;
    localparam ST_WAIT = 2'h1;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [7:0]       fast_drop_force_enable_q;
    reg  [7:0]       load_line_config_q;
    reg  [7:0]       zone_en_q;
    reg  [7:0]       fixed_cfg_q;
    reg  [7:0]       hyst_q;
    reg  [7:0]       delay_q;
    reg  [7:0]       th_q [1:4];
    reg              strap_done_q;
    reg              regulated_q;
    reg  [1:0]       mode_q;
    reg  [4:0]       self_en_q;
    reg  [7:0]       iout_q;
    reg  [CNT_W-1:0] sample_cnt_q;
    reg              tick_q;
    reg  [7:0]       wait_cnt_q;
    reg  [1:0]       state_q;
    reg  [CNT_W-1:0] force_cnt_q;
    reg              force_q;

    wire [N_PHASE-1:0] map_en;

    // ----------------------------------------
    // Zone availability and enables
    // ----------------------------------------
    function avail;
        input [2:0] z;
        input [3:0] n;
        begin
            case (z)
                3'h0: avail = 1'b1;
                3'h1: avail = (n == 4'h8) || (n == 4'h7); // [RL2]
                3'h2: avail = (n == 4'h8) || (n == 4'h7) || (n == 4'h6) || (n == 4'h4);
                3'h3: avail = (n >= 4'h2);
                3'h4: avail = 1'b1;
                default: avail = 1'b0;
            endcase
        end
    endfunction

    // Zone z (1..4) is bounded by threshold number 5-z
    reg [4:0] auto_en;
    reg [4:0] zone_ok;
    integer   k, j, m;
    always @* begin
        auto_en = 5'h01;
        for (k = 1; k <= 4; k = k + 1) begin
            auto_en[k] = avail(k[2:0], phase_count) && zone_en_q[k]
                         && (th_q[5 - k] != `PSZ_TH_DISABLED); // [RL21]
        end
        zone_ok = auto_en;
        if (mode_q == `PSZ_REQ_LOW)
            zone_ok = auto_en | self_en_q; // [RL13]
    end

    // ----------------------------------------
    // Target zone
    // ----------------------------------------
    reg [2:0] fixed_tgt;
    reg [2:0] shed_tgt;
    reg [2:0] target;
    reg       pass;
    reg [8:0] lim;
    always @* begin
        // Unavailable fixed request falls back to the nearest lower zone
        fixed_tgt = 3'h0;
        for (j = 1; j <= 4; j = j + 1) begin
            if (j <= fixed_cfg_q[2:0] && avail(j[2:0], phase_count))
                fixed_tgt = j[2:0]; // [RL4]
        end
        shed_tgt = 3'h0;
        pass     = 1'b1;
        lim      = 9'h000;
        for (j = 1; j <= 4; j = j + 1) begin
            if (auto_en[j]) begin
                if (j > zone_q) begin
                    lim  = {1'b0, th_q[5 - j]} - {1'b0, hyst_q};
                    pass = pass && !lim[8] && ({1'b0, iout_q} < lim); // [RL9]
                end else begin
                    pass = pass && (iout_q <= th_q[5 - j]); // [RL9]
                end
                if (pass)
                    shed_tgt = j[2:0]; // [RL5] [RL11]
            end
        end
        case (mode_q)
            `PSZ_REQ_HIGH: target = 3'h0; // [RL19]
            `PSZ_REQ_LOW:  target = fixed_tgt; // [RL4]
            `PSZ_REQ_MID:  target = regulated_q ? shed_tgt : zone_q; // [RL22]
            default:       target = zone_q;
        endcase
    end

    // Next enabled zone one step toward the target
    reg [2:0] step_up;
    reg [2:0] step_dn;
    always @* begin
        step_up = target;
        for (m = 4; m >= 1; m = m - 1) begin
            if (m > zone_q && m <= target && zone_ok[m])
                step_up = m[2:0]; // [RL8] [RL11]
        end
        step_dn = target;
        for (m = 0; m <= 4; m = m + 1) begin
            if (m < zone_q && m >= target && (m == 0 || zone_ok[m]))
                step_dn = m[2:0]; // [RL8] [RL11]
        end
    end

    // ----------------------------------------
    // Current sampling every 10 us
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            sample_cnt_q <= {CNT_W{1'b0}};
            tick_q       <= 1'b0;
            iout_q       <= 8'h00;
        end else begin
            tick_q <= (sample_cnt_q == SAMPLE_LAST);
            if (sample_cnt_q == SAMPLE_LAST) begin
                sample_cnt_q <= {CNT_W{1'b0}};
                iout_q       <= iout_code; // [RL18] [RL20]
            end else begin
                sample_cnt_q <= sample_cnt_q + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Mode tracking and self-enabled zones
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            regulated_q <= 1'b0;
            mode_q      <= `PSZ_REQ_LOW;
            self_en_q   <= 5'h00;
        end else begin
            if (output_in_regulation)
                regulated_q <= 1'b1;
            // Request changes ignored until first regulation
            if (regulated_q && power_state_request != 2'h3)
                mode_q <= power_state_request; // [RL22]
            if (mode_q == `PSZ_REQ_MID)
                self_en_q <= 5'h00; // [RL14]
            else if (mode_q == `PSZ_REQ_LOW && !auto_en[fixed_tgt])
                self_en_q <= self_en_q | (5'h01 << fixed_tgt); // [RL13]
        end
    end

    // ----------------------------------------
    // Zone sequencer
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            state_q    <= ST_HOLD;
            zone_q     <= 3'h0;
            wait_cnt_q <= 8'h00;
            dcm_mode_q <= 1'b0;
        end else begin
            dcm_mode_q <= (zone_q == 3'h4); // [RL3]
            case (state_q)
                ST_HOLD: begin
                    if (target < zone_q) begin
                        zone_q <= step_dn; // [RL6]
                    end else if (target > zone_q) begin
                        wait_cnt_q <= delay_q; // [RL7] [RL12]
                        state_q    <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Demand for more phases wins over a pending shed
                    if (target <= zone_q) begin
                        state_q <= ST_HOLD; // [RL23]
                    end else if (wait_cnt_q == 8'h00) begin
                        zone_q  <= step_up; // [RL8]
                        state_q <= ST_HOLD;
                    end else if (tick_q) begin
                        wait_cnt_q <= wait_cnt_q - 1'b1; // [RL7]
                    end
                end
                default: state_q <= ST_HOLD;
            endcase
        end
    end

    // ----------------------------------------
    // Fast reference drop forcing
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            force_q     <= 1'b0;
            force_cnt_q <= {CNT_W{1'b0}};
        end else if (fast_reference_drop
                     && fast_drop_force_enable_q[`PSZ_FAST_DROP_EN_BIT]
                     && (zone_q == 3'h3 || zone_q == 3'h4)) begin
            force_q     <= 1'b1; // [RL15]
            force_cnt_q <= {CNT_W{1'b0}};
        end else if (force_q) begin
            if (force_cnt_q == FORCE_LAST)
                force_q <= 1'b0; // [RL15]
            force_cnt_q <= force_cnt_q + 1'b1;
        end
    end

    psz_phase_map #(
        .N_PHASE     (N_PHASE)
    ) u_map (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .zone        (zone_q),
        .phase_count (phase_count),
        .force_all   (force_q),
        .drive_en    (map_en)
    );
    assign phase_drive_en = map_en; // [RL1]

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            fast_drop_force_enable_q <= `PSZ_RST_FAST_DROP;
            load_line_config_q       <= `PSZ_RST_LL_CFG;
            zone_en_q                <= `PSZ_RST_ZONE_EN;
            fixed_cfg_q              <= `PSZ_RST_FIXED_CFG;
            hyst_q                   <= `PSZ_RST_HYST; // [RL10]
            delay_q                  <= `PSZ_RST_DELAY;
            th_q[1]                  <= `PSZ_RST_TH;
            th_q[2]                  <= `PSZ_RST_TH;
            th_q[3]                  <= `PSZ_RST_TH;
            th_q[4]                  <= `PSZ_RST_TH;
            switching_frequency_q    <= `PSZ_RST_FSW;
            strap_done_q             <= 1'b0;
        end else begin
            // Strap caught once, first clock after reset release
            if (!strap_done_q) begin
                switching_frequency_q <= fsw_strap; // [RL16]
                strap_done_q          <= 1'b1;
            end
            if (reg_wr_en) begin
                case (reg_addr)
                    `PSZ_ADDR_FSW_CFG:   switching_frequency_q <= reg_wr_data; // [RL16]
                    `PSZ_ADDR_FAST_DROP: fast_drop_force_enable_q <= reg_wr_data;
                    `PSZ_ADDR_ZONE_EN:   zone_en_q <= reg_wr_data;
                    `PSZ_ADDR_FIXED_CFG: fixed_cfg_q <= reg_wr_data; // [RL12]
                    `PSZ_ADDR_LL_CFG:    load_line_config_q <= reg_wr_data;
                    `PSZ_ADDR_TH1_CFG:   th_q[1] <= reg_wr_data; // [RL21]
                    `PSZ_ADDR_TH2_CFG:   th_q[2] <= reg_wr_data;
                    `PSZ_ADDR_TH3_CFG:   th_q[3] <= reg_wr_data;
                    `PSZ_ADDR_TH4_CFG:   th_q[4] <= reg_wr_data;
                    `PSZ_ADDR_HYST_CFG:  hyst_q <= reg_wr_data; // [RL10]
                    `PSZ_ADDR_DELAY_CFG: delay_q <= reg_wr_data; // [RL7]
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Droop selection and register reads
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            droop_coeff_q <= `PSZ_DROOP_OFF;
            reg_rd_data_q <= 8'h00;
        end else begin
            // Coefficient only reaches the loop with load line on
            if (load_line_config_q[`PSZ_LL_EN_BIT])
                droop_coeff_q <= load_line_config_q[1:0]; // [RL17]
            else
                droop_coeff_q <= `PSZ_DROOP_OFF; // [RL17]
            if (reg_rd_en) begin
                case (reg_addr)
                    `PSZ_ADDR_FSW_STAT:   reg_rd_data_q <= switching_frequency_q; // [RL16]
                    `PSZ_ADDR_FSW_CFG:    reg_rd_data_q <= switching_frequency_q;
                    `PSZ_ADDR_FAST_DROP:  reg_rd_data_q <= fast_drop_force_enable_q;
                    `PSZ_ADDR_REQ_STAT:   reg_rd_data_q <= {5'h00, force_q, mode_q};
                    `PSZ_ADDR_PHASE_STAT: reg_rd_data_q <= map_en;
                    `PSZ_ADDR_ZONE_EN:    reg_rd_data_q <= zone_en_q;
                    `PSZ_ADDR_FIXED_STAT: reg_rd_data_q <= {3'h0, zone_ok};
                    `PSZ_ADDR_FIXED_CFG:  reg_rd_data_q <= fixed_cfg_q;
                    `PSZ_ADDR_LL_STAT:    reg_rd_data_q <= {6'h00, droop_coeff_q};
                    `PSZ_ADDR_LL_CFG:     reg_rd_data_q <= load_line_config_q;
                    `PSZ_ADDR_TH1_CFG:    reg_rd_data_q <= th_q[1];
                    `PSZ_ADDR_TH1_STAT:   reg_rd_data_q <= {4'h0, dcm_mode_q, zone_q};
                    `PSZ_ADDR_TH2_CFG:    reg_rd_data_q <= th_q[2];
                    `PSZ_ADDR_TH3_CFG:    reg_rd_data_q <= th_q[3];
                    `PSZ_ADDR_TH4_CFG:    reg_rd_data_q <= th_q[4];
                    `PSZ_ADDR_HYST_CFG:   reg_rd_data_q <= hyst_q;
                    `PSZ_ADDR_DELAY_CFG:  reg_rd_data_q <= delay_q;
                    default:              reg_rd_data_q <= 8'h00;
                endcase
            end
        end
    end

endmodule // psz_zone_ctrl

`default_nettype wire

// File: verif/psz_load_model.sv
// Far-side model: current monitor code and output regulation flag.
// Assumes the bench sets the load level; one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
module psz_load_model #(
    parameter SOFT_START = 6
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] load_level,
    output var  logic [7:0] iout_code,
    output var  logic       in_reg
);
    logic [3:0] ramp_q;
    // One-cycle converter lag; regulation after soft start
    always @(posedge clk) begin
        if (sys_rst) begin
            ramp_q <= 4'h0;
            in_reg <= 1'b0;
        end else begin
            if (ramp_q != SOFT_START[3:0])
                ramp_q <= ramp_q + 4'h1;
            in_reg <= (ramp_q == SOFT_START[3:0]);
        end
        iout_code <= load_level;
    end
endmodule // psz_load_model
`default_nettype wire

// File: verif/psz_zone_chk.sv
// Port checker for the zone sequencer.
// Assumes fast drop enable stays at its reset value.
`timescale 1ns/10ps
`default_nettype none
`include "psz_map.vh"
module psz_zone_chk #(
    parameter N_PHASE = 8
) (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic [1:0]         power_state_request,
    input wire logic [3:0]         phase_count,
    input wire logic               output_in_regulation,
    input wire logic               fast_reference_drop,
    input wire logic [7:0]         fsw_strap,
    input wire logic [N_PHASE-1:0] phase_drive_en,
    input wire logic [2:0]         zone_q,
    input wire logic               dcm_mode_q,
    input wire logic [1:0]         droop_coeff_q,
    input wire logic [7:0]         switching_frequency_q
);
    // ------------
    // Properties
    // ------------
    logic [8:0] full;
    assign full = (9'h001 << phase_count) - 9'h001;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_high_held;
        (power_state_request == `PSZ_REQ_HIGH && output_in_regulation) [*8];
    endsequence
    sequence s_drop_seen;
        fast_reference_drop && zone_q >= 3'h3;
    endsequence
    property p_rst_state;
        disable iff (1'b0) sys_rst |=> zone_q == 3'h0 && !dcm_mode_q
            && droop_coeff_q == `PSZ_DROOP_OFF;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
    property p_zone_range; zone_q <= 3'h4; endproperty
    a_zone_range: assert property (p_zone_range) else $error("zone out of range");
    property p_dcm_on; zone_q == 3'h4 |=> dcm_mode_q; endproperty
    a_dcm_on: assert property (p_dcm_on) else $error("light load mode missing");
    property p_dcm_off; zone_q != 3'h4 |=> !dcm_mode_q; endproperty
    a_dcm_off: assert property (p_dcm_off) else $error("light load mode stray");
    property p_high_all; s_high_held |-> ##[0:8] zone_q == 3'h0; endproperty
    a_high_all: assert property (p_high_all) else $error("high request not zone 0");
    property p_up_wait;
        zone_q > $past(zone_q) |-> $past(zone_q, 4) == $past(zone_q);
    endproperty
    a_up_wait: assert property (p_up_wait) else $error("step up without delay");
    property p_force;
        s_drop_seen |-> ##[1:3] (phase_drive_en == full[N_PHASE-1:0]) [*8];
    endproperty
    a_force: assert property (p_force) else $error("phases not forced on");
    property p_zone0_mask;
        zone_q == 3'h0 ##1 $stable(phase_count) |-> phase_drive_en == full[N_PHASE-1:0];
    endproperty
    a_zone0_mask: assert property (p_zone0_mask) else $error("zone 0 mask wrong");
    property p_fsw; $fell(sys_rst) |-> ##[1:2] switching_frequency_q == fsw_strap; endproperty
    a_fsw: assert property (p_fsw) else $error("frequency not captured");
endmodule // psz_zone_chk
bind psz_zone_ctrl psz_zone_chk #(.N_PHASE(N_PHASE)) u_chk (.clk, .sys_rst,
    .power_state_request, .phase_count, .output_in_regulation, .fast_reference_drop,
    .fsw_strap, .phase_drive_en, .zone_q, .dcm_mode_q, .droop_coeff_q, .switching_frequency_q);
`default_nettype wire

// File: verif/psz_zone_ctrl_tb.sv
// Self-checking bench for the zone sequencer and its settings.
// Assumes short sample and force counts set at the instance.
`timescale 1ns/10ps
`default_nettype none
`include "psz_map.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module psz_zone_ctrl_tb;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [1:0] power_state_request = `PSZ_REQ_HIGH;
    logic [3:0] phase_count = 4'h8;
    logic [7:0] load_level = 8'h00;
    logic       fast_reference_drop = 1'b0;
    logic [7:0] fsw_strap = 8'h5A;
    logic       reg_wr_en = 1'b0;
    logic       reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic [7:0] reg_rd_data_q, iout_code, switching_frequency_q, phase_drive_en;
    logic [2:0] zone_q;
    logic       dcm_mode_q, output_in_regulation;
    logic       saw_zone2 = 1'b0;
    logic [1:0] droop_coeff_q;
    int         errors = 0;
    int         check_count = 0;
    always #10 clk = ~clk;
    always @(posedge clk)
        if (zone_q === 3'h2 && power_state_request == `PSZ_REQ_MID) saw_zone2 <= 1'b1;
    psz_load_model u_load (.clk, .sys_rst, .load_level, .iout_code,
        .in_reg(output_in_regulation));
    psz_zone_ctrl #(.N_PHASE(8), .SAMPLE_CYCLES(4), .FORCE_CYCLES(20)) uut (.clk, .sys_rst,
        .power_state_request, .phase_count, .iout_code, .output_in_regulation,
        .fast_reference_drop, .fsw_strap, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
        .reg_rd_data_q, .phase_drive_en, .zone_q, .dcm_mode_q, .droop_coeff_q,
        .switching_frequency_q);
    // ------------
    // Shared tasks
    // ------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        @(negedge clk);
        `CHK(reg_rd_data_q, e)
    endtask
    // Bounded wait
    task automatic wait_zone(input logic [2:0] z, input logic [7:0] m);
        for (int i = 0; i < 400 && zone_q !== z; i++) begin
            @(posedge clk);
        end
        repeat (2) @(negedge clk);
        `CHK(zone_q, z)
        `CHK(phase_drive_en, m)
    endtask
    // ------------
    // Scenarios
    // ------------
    task automatic t_regs;
        rd_chk(`PSZ_ADDR_FAST_DROP, 8'h01);
        rd_chk(`PSZ_ADDR_HYST_CFG, 8'h44);
        rd_chk(`PSZ_ADDR_DELAY_CFG, 8'h14);
        rd_chk(`PSZ_ADDR_ZONE_EN, 8'h1F);
        rd_chk(8'h00, 8'h00);
        wr(`PSZ_ADDR_HYST_CFG, 8'h10);
        rd_chk(`PSZ_ADDR_HYST_CFG, 8'h10);
        wr(`PSZ_ADDR_DELAY_CFG, 8'h02);
        `CHK(switching_frequency_q, 8'h5A)
        wr(`PSZ_ADDR_FSW_CFG, 8'h33);
        repeat (2) @(negedge clk);
        `CHK(switching_frequency_q, 8'h33)
        $display("regs done");
    endtask
    task automatic t_droop;
        for (int i = 0; i < 5; i++) begin
            wr(`PSZ_ADDR_LL_CFG, (i < 4) ? 8'h04 + 8'(i) : 8'h01);
            repeat (2) @(negedge clk);
            `CHK(droop_coeff_q, (i < 4) ? 2'(i) : `PSZ_DROOP_OFF)
        end
        $display("droop done");
    endtask
    task automatic t_high;
        for (int n = 1; n <= 8; n++) begin
            @(posedge clk) phase_count <= 4'(n);
            repeat (3) @(negedge clk);
            `CHK(zone_q, 3'h0)
            `CHK(phase_drive_en, 8'((9'h001 << n) - 9'h001))
        end
        $display("high done");
    endtask
    task automatic t_fixed;
        wr(`PSZ_ADDR_FIXED_CFG, 8'h02);
        @(posedge clk);
        power_state_request <= `PSZ_REQ_LOW;
        phase_count <= 4'h7;
        repeat (5) @(negedge clk);
        `CHK(zone_q, 3'h0)
        wait_zone(3'h1, 8'h5D);
        wait_zone(3'h2, 8'h49);
        @(posedge clk) phase_count <= 4'h8;
        wr(`PSZ_ADDR_ZONE_EN, 8'h0F);
        wr(`PSZ_ADDR_FIXED_CFG, 8'h04);
        wait_zone(3'h3, 8'h01);
        wait_zone(3'h4, 8'h01);
        `CHK(dcm_mode_q, 1'b1)
        $display("fixed done");
    endtask
    task automatic t_mid;
        wr(`PSZ_ADDR_TH1_CFG, 8'h60);
        wr(`PSZ_ADDR_TH2_CFG, 8'h80);
        wr(`PSZ_ADDR_TH3_CFG, `PSZ_TH_DISABLED);
        wr(`PSZ_ADDR_TH4_CFG, 8'hC0);
        @(posedge clk);
        load_level <= 8'hFF;
        power_state_request <= `PSZ_REQ_MID;
        repeat (20) @(negedge clk);
        `CHK(zone_q, 3'h0)
        @(posedge clk) load_level <= 8'h75;
        wait_zone(3'h1, 8'h55);
        repeat (100) @(negedge clk);
        `CHK(zone_q, 3'h1)
        @(posedge clk);
        load_level <= 8'h00;
        wait_zone(3'h3, 8'h01);
        repeat (100) @(negedge clk);
        `CHK(zone_q, 3'h3)
        `CHK(saw_zone2, 1'b0)
        @(posedge clk) fast_reference_drop <= 1'b1;
        @(posedge clk) fast_reference_drop <= 1'b0;
        repeat (4) @(negedge clk);
        `CHK(phase_drive_en, 8'hFF)
        repeat (30) @(negedge clk);
        `CHK(phase_drive_en, 8'h01)
        $display("mid done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (12) @(posedge clk);
        t_regs;
        t_droop;
        t_high;
        t_fixed;
        t_mid;
        close_out;
    end
    // Run is under 2000 cycles
    initial begin
        #(20000 * 20);
        errors++;
        close_out;
    end
endmodule // psz_zone_ctrl_tb
`default_nettype wire
